/* File: core/sdram_front_pkg.sv */
// Shared constants and types for the SDRAM command and address front end.
// Assumes both clock domains include this package before any module.
`default_nettype none
package sdram_front_pkg;

    localparam int ADDR_W  = 13;
    localparam int BANKS   = 4;
    localparam int BANK_W  = 2;
    localparam int AP_BIT  = 10;

    // Burst length is not carried by this block; a fixed default is used.
    localparam logic [2:0] BURST_LEN = 3'h4;

    // Command codes as {select, row, column, write} strobe levels.
    localparam logic [3:0] CMD_MODE_SET   = 4'h0;
    localparam logic [3:0] CMD_REFRESH    = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE  = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE   = 4'h3;
    localparam logic [3:0] CMD_WRITE      = 4'h4;
    localparam logic [3:0] CMD_READ       = 4'h5;
    localparam logic [3:0] CMD_BURST_STOP = 4'h6;
    localparam logic [3:0] CMD_NOP        = 4'h7;

    localparam logic [1:0] ORG_X4  = 2'h0;
    localparam logic [1:0] ORG_X8  = 2'h1;
    localparam logic [1:0] ORG_X16 = 2'h2;

    localparam logic [12:0] COL_MASK_X4  = 13'h0bff;
    localparam logic [12:0] COL_MASK_X8  = 13'h03ff;
    localparam logic [12:0] COL_MASK_X16 = 13'h01ff;

    localparam logic [3:0] ALL_BANKS = 4'hf;

    typedef enum logic [3:0] {
        PWR_RUN          = 4'h1,
        PWR_DOWN         = 4'h2,
        PWR_SUSPEND      = 4'h4,
        PWR_SELF_REFRESH = 4'h8
    } power_e;

    typedef struct packed {
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              dm;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } pin_s;

    typedef struct packed {
        logic [BANKS-1:0]  open_mask;
        logic [BANKS-1:0]  close_mask;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic [BANK_W-1:0] bank;
        logic [3:0]        cmd;
    } bank_op_s;

endpackage
`default_nettype wire

/* File: core/level_sync.sv */
// Two flip-flop synchroniser for levels and toggles.
// Assumes the input changes no faster than the receiving clock can follow.
`default_nettype none
module level_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        meta_reg <= d;
        q        <= meta_reg;
    end

endmodule
`default_nettype wire

/* File: core/bank_tracker.sv */
// Open flag and open row of one internal bank.
// Assumes open and close never name the same bank in one cycle.
`default_nettype none
module bank_tracker
    import sdram_front_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              open_en,
    input  wire logic              close_en,
    input  wire logic [ADDR_W-1:0] row,
    output logic                   is_open,
    output logic      [ADDR_W-1:0] open_row
);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            is_open <= 1'b0;
        end else if (open_en) begin
            is_open <= 1'b1;
        end else if (close_en) begin
            is_open <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            open_row <= '0;
        end else if (open_en) begin
            open_row <= row;
        end
    end

endmodule
`default_nettype wire

/* File: core/sdram_command_address_decode.sv */
// Command and address front end of a four-bank synchronous DRAM.
// Assumes the controller drives all pins and mem_clk; pins change on
// mem_clk only, so they are captured with no synchroniser.
`default_nettype none

// Behaviour
// - Every pin is captured only on the rising memory clock edge.
// - Clock gate low suspends clock: power-down, suspend or self-refresh.
// - Commands are decoded only when chip select is sampled low.
// - Chip select high ignores new commands; running bursts continue.
// - Row, column and write strobes together select the command.
// - Activate latches the 13-bit address as the row to open.
// - Column width follows organisation: x4 2048, x8 1024, x16 512.
// - Read or write with auto precharge closes its bank after burst, unless a read, write or burst stop cuts the burst short.
// - Read or write without auto precharge leaves the bank open.
// - Precharge with auto precharge bit high closes all four banks.
// - Precharge with auto precharge bit low closes the selected bank.
// - Bank select picks which bank a bank command acts on.
// - Fixed strobe encodings identify each of the eight commands.
// - Mask blocks read drivers two cycles later, write data same cycle.
module sdram_command_address_decode
    import sdram_front_pkg::*;
(
    input  wire logic                         core_clk,
    input  wire logic                         rst_b,
    input  wire logic                         mem_clk,
    input  wire pin_s                         pins,
    input  wire logic [1:0]                   organisation,
    output logic                              data_oe_b,
    output logic                              array_wr_en,
    output power_e                            power_state,
    output logic                              cmd_strobe,
    output logic      [3:0]                   last_cmd,
    output logic      [BANK_W-1:0]            last_bank,
    output logic      [ADDR_W-1:0]            last_col,
    output logic      [BANKS-1:0]             bank_open,
    output logic      [BANKS-1:0][ADDR_W-1:0] open_row
);

    ////////////////////////////////////////////////////////////////////////
    // Link-domain reset and straps.

    logic       link_rst_b;
    logic [1:0] org_sync;
    level_sync #(.W(1)) u_rst_sync (
        .clk (mem_clk),
        .d   (rst_b),
        .q   (link_rst_b)
    );
    level_sync #(.W(2)) u_org_sync (
        .clk (mem_clk),
        .d   (organisation),
        .q   (org_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin capture and command decode.

    pin_s       cap_reg;
    logic       cke_prev_reg;
    logic       run;
    logic [3:0] code;
    logic       dec_en;
    logic       ap;
    logic [3:0] bank_bit;
    logic       is_act;
    logic       is_pre;
    logic       is_rd;
    logic       is_wr;
    logic       is_stop;
    logic       is_ref;
    logic       is_mrs;
    logic [12:0] col_mask;

    always_ff @(posedge mem_clk) begin
        if (!link_rst_b) begin
            cap_reg      <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1,
                              cas_n: 1'b1, we_n: 1'b1, default: '0};
            cke_prev_reg <= 1'b0;
        end else begin
            cap_reg      <= pins;
            cke_prev_reg <= cap_reg.cke;
        end
    end

    assign run = cke_prev_reg;
    assign code     = {cap_reg.cs_n, cap_reg.ras_n,
                       cap_reg.cas_n, cap_reg.we_n};
    assign dec_en   = run & ~cap_reg.cs_n;
    assign ap       = cap_reg.addr[AP_BIT];
    assign bank_bit = 4'h1 << cap_reg.bank;
    assign is_act   = dec_en & (code == CMD_ACTIVATE);
    assign is_pre   = dec_en & (code == CMD_PRECHARGE);
    assign is_rd    = dec_en & (code == CMD_READ);
    assign is_wr    = dec_en & (code == CMD_WRITE);
    assign is_stop  = dec_en & (code == CMD_BURST_STOP);
    assign is_ref   = dec_en & (code == CMD_REFRESH);
    assign is_mrs   = dec_en & (code == CMD_MODE_SET);

    always_comb begin
        unique case (org_sync)
            ORG_X4:  col_mask = COL_MASK_X4;
            ORG_X8:  col_mask = COL_MASK_X8;
            ORG_X16: col_mask = COL_MASK_X16;
            default: col_mask = COL_MASK_X8;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst tracking. A burst keeps running while the chip is deselected.

    logic [2:0]        burst_cnt_reg;
    logic              burst_rd_reg;
    logic              burst_wr_reg;
    logic              burst_ap_reg;
    logic [BANK_W-1:0] burst_bank_reg;
    logic              burst_busy;
    logic              burst_end;
    assign burst_busy = burst_cnt_reg != 3'h0;
    assign burst_end  = run & (burst_cnt_reg == 3'h1) & ~is_rd & ~is_wr
                        & ~is_stop;

    always_ff @(posedge mem_clk) begin
        if (!link_rst_b) begin
            burst_cnt_reg  <= 3'h0;
            burst_rd_reg   <= 1'b0;
            burst_wr_reg   <= 1'b0;
            burst_ap_reg   <= 1'b0;
            burst_bank_reg <= '0;
        end else if (is_rd || is_wr) begin
            burst_cnt_reg  <= BURST_LEN - 3'h1;
            burst_rd_reg   <= is_rd;
            burst_wr_reg   <= is_wr;
            burst_ap_reg   <= ap;
            burst_bank_reg <= cap_reg.bank;
        end else if (is_stop) begin
            burst_cnt_reg  <= 3'h0;
        end else if (run && burst_busy) begin
            burst_cnt_reg  <= burst_cnt_reg - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data mask. A four-beat burst spans its command and the next three cycles.

    logic       rd_now;
    logic       wr_now;
    logic [1:0] rd_pipe_reg;
    logic [1:0] dm_pipe_reg;
    assign rd_now = is_rd | (burst_rd_reg & burst_busy & run);
    assign wr_now = is_wr | (burst_wr_reg & burst_busy & run);

    always_ff @(posedge mem_clk) begin
        if (!link_rst_b) begin
            rd_pipe_reg <= 2'h0;
            dm_pipe_reg <= 2'h0;
        end else if (run) begin
            rd_pipe_reg <= {rd_pipe_reg[0], rd_now};
            dm_pipe_reg <= {dm_pipe_reg[0], cap_reg.dm};
        end
    end

    assign data_oe_b   = ~(rd_pipe_reg[1] & ~dm_pipe_reg[1]);
    assign array_wr_en = wr_now & ~cap_reg.dm;

    ////////////////////////////////////////////////////////////////////////
    // Power state.

    power_e pwr_reg;
    always_ff @(posedge mem_clk) begin
        if (!link_rst_b) begin
            pwr_reg <= PWR_RUN;
        end else begin
            unique case (pwr_reg)
                PWR_RUN: begin
                    if (run && !cap_reg.cke) begin
                        if (is_ref) begin
                            pwr_reg <= PWR_SELF_REFRESH;
                        end else if (burst_busy) begin
                            pwr_reg <= PWR_SUSPEND;
                        end else begin
                            pwr_reg <= PWR_DOWN;
                        end
                    end
                end
                PWR_DOWN, PWR_SUSPEND: begin
                    if (cap_reg.cke) begin
                        pwr_reg <= PWR_RUN;
                    end
                end
                PWR_SELF_REFRESH: begin
                    if (cap_reg.cke && cap_reg.cs_n) begin
                        pwr_reg <= PWR_RUN;
                    end
                end
                default: pwr_reg <= PWR_RUN;
            endcase
        end
    end

    assign power_state = pwr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Bank operation record, handed over by toggle.

    bank_op_s op_next;
    bank_op_s op_reg;
    logic     op_send;
    logic     tog_reg;
    always_comb begin
        op_next            = '0;
        op_next.row        = cap_reg.addr;
        op_next.col        = cap_reg.addr & col_mask;
        op_next.bank       = cap_reg.bank;
        op_next.cmd        = code;
        if (is_act) begin
            op_next.open_mask = bank_bit;
        end
        if (is_pre) begin
            op_next.close_mask = ap ? ALL_BANKS : bank_bit;
        end
        if (burst_end && burst_ap_reg) begin
            op_next.close_mask = op_next.close_mask
                                 | (4'h1 << burst_bank_reg);
        end
    end

    assign op_send = is_act | is_pre | is_rd | is_wr | is_stop | is_ref
                     | is_mrs | (burst_end & burst_ap_reg);
    // The record stays put until the next send, which is at least one
    // link period away; that outlasts the three-edge toggle crossing.
    always_ff @(posedge mem_clk) begin
        if (!link_rst_b) begin
            op_reg  <= '0;
            tog_reg <= 1'b0;
        end else if (op_send) begin
            op_reg  <= op_next;
            tog_reg <= ~tog_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain.

    logic tog_sync;
    logic tog_seen_reg;
    logic take;
    level_sync #(.W(1)) u_tog_sync (
        .clk (core_clk),
        .d   (tog_reg),
        .q   (tog_sync)
    );

    assign take = tog_sync ^ tog_seen_reg;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tog_seen_reg <= 1'b0;
            cmd_strobe   <= 1'b0;
            last_cmd     <= CMD_NOP;
            last_bank    <= '0;
            last_col     <= '0;
        end else begin
            tog_seen_reg <= tog_sync;
            cmd_strobe   <= take;
            if (take) begin
                last_cmd  <= op_reg.cmd;
                last_bank <= op_reg.bank;
                last_col  <= op_reg.col;
            end
        end
    end

    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        bank_tracker u_bank (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .open_en  (take & op_reg.open_mask[b]),
            .close_en (take & op_reg.close_mask[b]),
            .row      (op_reg.row),
            .is_open  (bank_open[b]),
            .open_row (open_row[b])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_rd_masked;
        rd_now && cap_reg.dm && run ##1 run;
    endsequence
    sequence s_ap_burst_last;
        burst_end && burst_ap_reg;
    endsequence
    chk_capture_edge: assert property (
        @(posedge mem_clk) disable iff (!link_rst_b)
        $past(link_rst_b) |-> cap_reg == $past(pins))
        else $error("capture does not follow pins");
    chk_power_entry: assert property (
        @(posedge mem_clk) disable iff (!link_rst_b)
        pwr_reg == PWR_RUN && run && !cap_reg.cke
        |=> pwr_reg != PWR_RUN)
        else $error("clock gate low did not leave run state");
    chk_deselect_ignored: assert property (
        @(posedge mem_clk) disable iff (!link_rst_b)
        cap_reg.cs_n |-> !is_rd && !is_wr && op_next.open_mask == 4'h0)
        else $error("command taken while deselected");
    chk_activate_open: assert property (
        @(posedge mem_clk) disable iff (!link_rst_b)
        is_act |=> op_reg.open_mask == $past(bank_bit)
                   && op_reg.row == $past(cap_reg.addr))
        else $error("activate record wrong");
    chk_ap_close: assert property (
        @(posedge mem_clk) disable iff (!link_rst_b)
        s_ap_burst_last |=> op_reg.close_mask[$past(burst_bank_reg)])
        else $error("auto precharge bank not closed");
    chk_no_ap_open: assert property (
        @(posedge mem_clk) disable iff (!link_rst_b)
        burst_end && !burst_ap_reg && !is_pre |-> op_next.close_mask == 4'h0)
        else $error("bank closed without auto precharge");
    chk_pre_all: assert property (
        @(posedge mem_clk) disable iff (!link_rst_b)
        is_pre && ap |-> op_next.close_mask == ALL_BANKS)
        else $error("precharge all missed a bank");
    chk_pre_one: assert property (
        @(posedge mem_clk) disable iff (!link_rst_b)
        is_pre && !ap && !burst_end |-> op_next.close_mask == bank_bit)
        else $error("single precharge hit wrong bank");
    chk_read_mask: assert property (
        @(posedge mem_clk) disable iff (!link_rst_b)
        s_rd_masked |=> data_oe_b)
        else $error("masked read still drives two cycles later");
    chk_write_mask: assert property (
        @(posedge mem_clk) disable iff (!link_rst_b)
        cap_reg.dm |-> !array_wr_en)
        else $error("masked write reached the array");
    chk_bank_update: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        take && op_reg.open_mask != 4'h0
        |=> (bank_open & $past(op_reg.open_mask)) == $past(op_reg.open_mask))
        else $error("activated bank not marked open");
    chk_strobe_pulse: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        cmd_strobe |=> !cmd_strobe)
        else $error("command strobe longer than one cycle");

endmodule
`default_nettype wire

/* File: verification/sdram_ctrl_model.sv */
// Behavioural memory controller that drives the front end pins.
// Assumes the bench makes mem_clk and calls these tasks in order.
`default_nettype none
module sdram_ctrl_model
    import sdram_front_pkg::*;
(
    input  wire logic mem_clk,
    output var  pin_s pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cke_level;
    logic mask_level;

    initial begin
        cke_level  = 1'b1;
        mask_level = 1'b0;
        pins       = {1'b1, 4'hf, 16'h0000};
    end

    ////////////////////////////////////////////////////////////////////////
    // deselect, clock gate
    // Random strobes under a high select expose a decoder that ignores it.
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge mem_clk);
            pins <= {cke_level, 1'b1, 3'($urandom), mask_level,
                     15'($urandom)};
        end
    endtask

    task automatic issue(input logic [3:0] code, input logic [1:0] b,
                         input logic [12:0] a);
        @(posedge mem_clk);
        pins <= {cke_level, code, mask_level, b, a};
        idle(1);
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_sdram_command_address_decode.sv */
// Self-checking bench for the command and address front end.
// Assumes the controller model drives every pin on mem_clk.
`default_nettype none
module tb_sdram_command_address_decode
    import sdram_front_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                         core_clk;
    logic                         rst_b;
    logic                         mem_clk;
    pin_s                         pins;
    logic [1:0]                   organisation;
    logic                         data_oe_b;
    logic                         array_wr_en;
    power_e                       power_state;
    logic                         cmd_strobe;
    logic [3:0]                   last_cmd;
    logic [BANK_W-1:0]            last_bank;
    logic [ADDR_W-1:0]            last_col;
    logic [BANKS-1:0]             bank_open;
    logic [BANKS-1:0][ADDR_W-1:0] open_row;
    int                           miscompares = 0;
    int                           comparisons = 0;
    int                           rec_cnt = 0;
    int                           wr_seen = 0;
    int                           rd_seen = 0;
    int                           cycles = 0;

    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;
    // Rising link edges never meet a rising core edge, so no sampling race between them.
    initial mem_clk = 1'b0;
    always #80 mem_clk = ~mem_clk;

    sdram_ctrl_model ctrl (.mem_clk(mem_clk), .pins(pins));

    sdram_command_address_decode uut (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .mem_clk      (mem_clk),
        .pins         (pins),
        .organisation (organisation),
        .data_oe_b    (data_oe_b),
        .array_wr_en  (array_wr_en),
        .power_state  (power_state),
        .cmd_strobe   (cmd_strobe),
        .last_cmd     (last_cmd),
        .last_bank    (last_bank),
        .last_col     (last_col),
        .bank_open    (bank_open),
        .open_row     (open_row)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The ceiling is about twenty times the expected length of the run.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cmd_strobe === 1'b1) rec_cnt <= rec_cnt + 1;
        if (array_wr_en === 1'b1) wr_seen <= wr_seen + 1;
        if (data_oe_b === 1'b0) rd_seen <= rd_seen + 1;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic wait_recs(input int base, input int n);
        int k;
        k = 0;
        while (rec_cnt < base + n && k < 300) begin
            @(posedge core_clk);
            k++;
        end
        check(32'(rec_cnt - base), 32'(n));
        repeat (2) @(posedge core_clk);
    endtask

    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask

    function automatic logic [12:0] col_mask(input logic [1:0] org);
        case (org)
            ORG_X4:  return COL_MASK_X4;
            ORG_X16: return COL_MASK_X16;
            default: return COL_MASK_X8;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [12:0] a;
        logic [1:0]  b;
        logic [3:0]  c;
        logic [12:0] row_exp [BANKS];
        int          n;
        void'($urandom(32'ha510));
        rst_b        = 1'b0;
        organisation = ORG_X4;
        repeat (10) @(posedge mem_clk);
        @(posedge core_clk);
        rst_b <= 1'b1;
        ctrl.idle(3);
        check(32'(power_state), 32'(PWR_RUN));
        end_test("reset");

        for (int i = 0; i < BANKS; i++) begin
            row_exp[i] = (i == 3) ? 13'h1fff : 13'($urandom);
            n = rec_cnt;
            ctrl.issue(CMD_ACTIVATE, 2'(i), row_exp[i]);
            wait_recs(n, 1);
            check(32'(last_cmd), 32'(CMD_ACTIVATE));
            check(32'(open_row[i]), 32'(row_exp[i]));
        end
        check(32'(bank_open), 32'hf);
        end_test("activate");

        n = rec_cnt;
        ctrl.issue(4'ha, 2'($urandom), 13'($urandom));
        ctrl.idle(4);
        check(32'(rec_cnt - n), 32'h0);
        check(32'(bank_open), 32'hf);
        end_test("deselect");

        for (int o = 0; o < 4; o++) begin
            @(posedge core_clk);
            organisation <= 2'(o);
            for (int k = 0; k < 4; k++) begin
                b = 2'($urandom);
                a = (k == 3) ? 13'h1bff : 13'($urandom) & 13'h1bff;
                c = k[0] ? CMD_READ : CMD_WRITE;
                n = rec_cnt;
                ctrl.issue(c, b, a);
                ctrl.idle(4);
                wait_recs(n, 1);
                check(32'(last_cmd), 32'(c));
                check(32'(last_col), 32'(a & col_mask(2'(o))));
                check(32'(last_bank), 32'(b));
                check(32'(bank_open), 32'hf);
            end
        end
        end_test("column");

        n = rec_cnt;
        ctrl.issue(CMD_READ, 2'h1, 13'h0400 | 13'($urandom & 32'h1ff));
        ctrl.idle(6);
        wait_recs(n, 2);
        check(32'(bank_open), 32'hd);
        n = rec_cnt;
        ctrl.issue(CMD_WRITE, 2'h2, 13'($urandom) | 13'h0400);
        ctrl.idle(6);
        wait_recs(n, 2);
        check(32'(bank_open), 32'h9);
        end_test("auto close");

        for (int i = 1; i < 3; i++) begin
            n = rec_cnt;
            ctrl.issue(CMD_ACTIVATE, 2'(i), 13'($urandom));
            wait_recs(n, 1);
        end
        n = rec_cnt;
        ctrl.issue(CMD_PRECHARGE, 2'h0, 13'($urandom) & 13'h1bff);
        wait_recs(n, 1);
        check(32'(bank_open), 32'he);
        n = rec_cnt;
        ctrl.issue(CMD_PRECHARGE, 2'($urandom), 13'($urandom) | 13'h0400);
        wait_recs(n, 1);
        check(32'(bank_open), 32'h0);
        end_test("precharge");

        for (int i = 0; i < 3; i++) begin
            c = (i == 0) ? CMD_MODE_SET :
                (i == 1) ? CMD_REFRESH : CMD_BURST_STOP;
            n = rec_cnt;
            ctrl.issue(c, 2'($urandom), 13'($urandom));
            wait_recs(n, 1);
            check(32'(last_cmd), 32'(c));
            check(32'(bank_open), 32'h0);
        end
        end_test("other codes");

        n = rec_cnt;
        ctrl.issue(CMD_ACTIVATE, 2'h0, 13'($urandom));
        wait_recs(n, 1);
        for (int m = 0; m < 4; m++) begin
            ctrl.mask_level = m[0];
            wr_seen = 0;
            rd_seen = 0;
            ctrl.issue(m[1] ? CMD_READ : CMD_WRITE, 2'($urandom),
                       13'($urandom) & 13'h1bff);
            ctrl.idle(6);
            if (m[1]) check(32'(rd_seen > 0), 32'(!m[0]));
            else check(32'(wr_seen > 0), 32'(!m[0]));
        end
        ctrl.mask_level = 1'b0;
        end_test("mask");

        // The state moves at the third edge; look one edge later.
        ctrl.cke_level = 1'b0;
        ctrl.idle(4);
        check(32'(power_state), 32'(PWR_DOWN));
        ctrl.cke_level = 1'b1;
        ctrl.idle(4);
        check(32'(power_state), 32'(PWR_RUN));
        ctrl.issue(CMD_READ, 2'($urandom), 13'($urandom) & 13'h1bff);
        ctrl.cke_level = 1'b0;
        ctrl.idle(4);
        check(32'(power_state), 32'(PWR_SUSPEND));
        ctrl.cke_level = 1'b1;
        ctrl.idle(4);
        check(32'(power_state), 32'(PWR_RUN));
        ctrl.cke_level = 1'b0;
        ctrl.issue(CMD_REFRESH, 2'($urandom), 13'($urandom));
        ctrl.idle(2);
        check(32'(power_state), 32'(PWR_SELF_REFRESH));
        ctrl.cke_level = 1'b1;
        ctrl.idle(4);
        check(32'(power_state), 32'(PWR_RUN));
        end_test("power");
        print_verdict();
    end
endmodule
`default_nettype wire
